// *** design/hfa_pkg.sv ***
// package of constants for the half-flash converter bus controller
// assumes a 50 MHz ref_clk and a clockless converter on the far side
// Function
// - conversion starts when select and read fall low
// - mode chosen only by read strobe length
// - mode 0 host holds strobes until conversion ends
// - mode 1 host reads again to fetch result
// - mode 1 reads spaced at least 2.5us apart
// - at least 500ns between conversion end and start
// - mode 1 read pulse 60 to 600ns
package hfa_pkg;
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned CONV_MAX_NS    = 2000;
  localparam int unsigned RD_PULSE_MIN_NS = 60;
  localparam int unsigned RD_PULSE_MAX_NS = 600;
  localparam int unsigned READ_GAP_NS    = 2500;
  localparam int unsigned CONV_GAP_NS    = 500;
  localparam int unsigned DATA_ACC_NS    = 85;
  // least times round up, longest round down
  localparam int unsigned CONV_MAX_CYC   = (CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned RD_MIN_CYC     = (RD_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RD_MAX_CYC     = (RD_PULSE_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned READ_GAP_CYC   = (READ_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_GAP_CYC   = (CONV_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACC_CYC        = (DATA_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W          = 8;
  localparam logic [7:0]  RESULT_RST     = 8'h00;
  typedef enum logic [2:0] {
    HFA_IDLE  = 3'b000,
    HFA_WAIT0 = 3'b001,
    HFA_PULSE = 3'b010,
    HFA_GAP   = 3'b011,
    HFA_FAIL  = 3'b100
  } hfa_state_t;
endpackage

// *** design/hfa_sync.sv ***
// two flip-flop synchroniser for pin inputs
// assumes inputs arrive asynchronously to ref_clk
`timescale 1ns/1ns
module hfa_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // async in, synced out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// *** design/hfa_host.sv ***
// host controller driving the half-flash converter through its strobes
// assumes the converter pins are wired directly; ready pin pulled up outside
`timescale 1ns/1ns
module hfa_host #(
  parameter int CHANNELS = 8,
  parameter int AW       = (CHANNELS == 8) ? 3 : 2
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  // user command port
  input  wire logic          start,
  input  wire logic          pipelined,
  input  wire logic [AW-1:0] channel,
  output logic               busy,
  output logic               result_valid,
  output logic [7:0]         result,
  output logic [AW-1:0]      result_chan,
  output logic               timeout,
  // converter pins
  output logic               cs_n,
  output logic               rd_n,
  output logic [AW-1:0]      chan_sel,
  input  wire logic [7:0]    result_bus,
  input  wire logic          done_n,
  input  wire logic          ready_in
);
  localparam logic [hfa_pkg::CNT_W-1:0] C_CONV = hfa_pkg::CNT_W'(hfa_pkg::CONV_MAX_CYC + 10);
  localparam logic [hfa_pkg::CNT_W-1:0] C_PULSE =
    hfa_pkg::CNT_W'((hfa_pkg::RD_MIN_CYC > hfa_pkg::ACC_CYC + 2) ?
                    hfa_pkg::RD_MIN_CYC : hfa_pkg::ACC_CYC + 2);
  localparam logic [hfa_pkg::CNT_W-1:0] C_RGAP = hfa_pkg::CNT_W'(hfa_pkg::READ_GAP_CYC);
  localparam logic [hfa_pkg::CNT_W-1:0] C_CGAP = hfa_pkg::CNT_W'(hfa_pkg::CONV_GAP_CYC);

  // synchronised pin inputs
  logic [9:0] pins_s;
  hfa_sync #(.W(10), .INIT(10'h300)) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     ({done_n, ready_in, result_bus}),
    .dout    (pins_s)
  );
  logic       done_s;
  logic       ready_s;
  logic [7:0] bus_s;
  assign done_s  = pins_s[9];
  assign ready_s = pins_s[8];
  assign bus_s   = pins_s[7:0];

  // further counter bounds, all in ref_clk cycles
  // status pins are only trusted once the data access time, ACC_CYC cycles, has passed
  localparam logic [hfa_pkg::CNT_W-1:0] C_TRUST =
    hfa_pkg::CNT_W'(hfa_pkg::ACC_CYC);
  // one cycle beyond the read spacing, since the spacing is counted from the fall
  localparam logic [hfa_pkg::CNT_W-1:0] C_RGAP_END =
    hfa_pkg::CNT_W'(hfa_pkg::READ_GAP_CYC + 1);
  localparam logic [hfa_pkg::CNT_W-1:0] C_ONE = hfa_pkg::CNT_W'(1);

  // sequencer state and its next values
  hfa_pkg::hfa_state_t       state;
  hfa_pkg::hfa_state_t       next_state;
  logic [hfa_pkg::CNT_W-1:0] cnt;
  logic [hfa_pkg::CNT_W-1:0] next_cnt;
  logic                      mode1;
  logic                      next_mode1;
  logic                      pass2;
  logic                      next_pass2;
  logic                      done_seen;
  logic                      next_done_seen;

  // next values of the registered outputs
  logic                      next_cs_n;
  logic                      next_rd_n;
  logic [AW-1:0]             next_chan_sel;
  logic [7:0]                next_result;
  logic [AW-1:0]             next_result_chan;
  logic                      next_result_valid;
  logic                      next_timeout;

  // a request is only taken while idle
  assign busy = (state != hfa_pkg::HFA_IDLE);

  // next-state logic of the strobe sequencer
  // mode is chosen purely by how long the strobes are held low
  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_mode1        = mode1;
    next_pass2        = pass2;
    next_done_seen    = done_seen;
    next_cs_n         = 1'b1;
    next_rd_n         = 1'b1;
    next_chan_sel     = chan_sel;
    next_result       = result;
    next_result_chan  = result_chan;
    next_result_valid = 1'b0;
    next_timeout      = timeout;
    unique case (state)
      hfa_pkg::HFA_IDLE: begin
        if (start) begin
          // address is set up one cycle ahead of the strobes, so it never races them
          next_chan_sel  = channel;
          next_mode1     = pipelined;
          next_pass2     = 1'b0;
          next_done_seen = 1'b0;
          next_timeout   = 1'b0;
          next_cnt       = '0;
          if (pipelined) begin
            next_state = hfa_pkg::HFA_PULSE;
          end else begin
            next_state = hfa_pkg::HFA_WAIT0;
          end
        end
      end
      hfa_pkg::HFA_WAIT0: begin
        // both strobes fall together and stay low until the result is in or the count reaches C_CONV
        next_cs_n = 1'b0;
        next_rd_n = 1'b0;
        next_cnt  = cnt + C_ONE;
        if (done_seen) begin
          // data pins were sampled one cycle after done, so the word has settled
          next_result       = bus_s;
          next_result_chan  = chan_sel;
          next_result_valid = 1'b1;
          next_cs_n         = 1'b1;
          next_rd_n         = 1'b1;
          next_cnt          = '0;
          next_state        = hfa_pkg::HFA_GAP;
        end else if (cnt >= C_TRUST && !done_s && ready_s) begin
          // ready guards against a done flag left low by an earlier conversion
          next_done_seen = 1'b1;
        end else if (cnt == C_CONV) begin
          next_state = hfa_pkg::HFA_FAIL;
        end
      end
      hfa_pkg::HFA_PULSE: begin
        // short read pulse, long enough for data access, well under the upper bound
        next_cnt = cnt + C_ONE;
        if (cnt == C_PULSE) begin
          // the second read of a pair fetches the word that the first one started
          if (pass2) begin
            next_result       = bus_s;
            next_result_chan  = chan_sel;
            next_result_valid = 1'b1;
          end
          next_state = hfa_pkg::HFA_GAP;
        end else begin
          next_cs_n = 1'b0;
          next_rd_n = 1'b0;
        end
      end
      hfa_pkg::HFA_GAP: begin
        next_cnt = cnt + C_ONE;
        if (mode1) begin
          // spacing counted from the falling strobe of the last read
          if (cnt == C_RGAP_END) begin
            next_cnt = '0;
            if (pass2) begin
              next_state = hfa_pkg::HFA_IDLE;
            end else begin
              next_pass2 = 1'b1;
              next_state = hfa_pkg::HFA_PULSE;
            end
          end
        end else begin
          // rest time after a conversion before the next may start
          if (cnt == C_CGAP) begin
            next_cnt   = '0;
            next_state = hfa_pkg::HFA_IDLE;
          end
        end
      end
      hfa_pkg::HFA_FAIL: begin
        // the converter never answered: release the bus and flag it
        next_timeout      = 1'b1;
        next_result       = bus_s;
        next_result_chan  = chan_sel;
        next_result_valid = 1'b1;
        next_cnt          = '0;
        next_state        = hfa_pkg::HFA_GAP;
      end
    endcase
  end

  // registers of the strobe sequencer and its outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state        <= hfa_pkg::HFA_IDLE;
      cnt          <= '0;
      mode1        <= 1'b0;
      pass2        <= 1'b0;
      done_seen    <= 1'b0;
      cs_n         <= 1'b1;
      rd_n         <= 1'b1;
      chan_sel     <= '0;
      result       <= hfa_pkg::RESULT_RST;
      result_chan  <= '0;
      result_valid <= 1'b0;
      timeout      <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      mode1        <= next_mode1;
      pass2        <= next_pass2;
      done_seen    <= next_done_seen;
      cs_n         <= next_cs_n;
      rd_n         <= next_rd_n;
      chan_sel     <= next_chan_sel;
      result       <= next_result;
      result_chan  <= next_result_chan;
      result_valid <= next_result_valid;
      timeout      <= next_timeout;
    end
  end
endmodule

// *** tb/hfa_monitor.sv ***
// checker of host strobe timing
// assumes package cycle counts at 50 MHz
`timescale 1ns/1ns
module hfa_monitor (
  input wire logic ref_clk, resetn, pipelined, cs_n, rd_n, done_n
);
  localparam int RMAX = hfa_pkg::RD_MAX_CYC;
  localparam logic [7:0] RGAP = 8'(hfa_pkg::READ_GAP_CYC);
  localparam logic [7:0] CGAP = 8'(hfa_pkg::CONV_GAP_CYC);
  logic [7:0] sr, sd; // age of read start, of done
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn) {sr, sd} <= 16'hFFFF;
    else begin
      sr <= $fell(rd_n) ? 8'h00 : sr + 8'(sr != 8'hFF);
      sd <= $fell(done_n) ? 8'h00 : sd + 8'(sd != 8'hFF);
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_sel; !rd_n |-> !cs_n; endproperty
  a_sel: assert property (p_sel) else $error("read unselected");
  property p_hold; !pipelined && !rd_n && done_n |=> !rd_n; endproperty
  a_hold: assert property (p_hold) else $error("early release");
  property p_long; $fell(rd_n) && !pipelined |-> !rd_n[*8]; endproperty
  a_long: assert property (p_long) else $error("short wait read");
  property p_spc; $fell(rd_n) && pipelined |-> sr >= RGAP; endproperty
  a_spc: assert property (p_spc) else $error("reads too close");
  property p_gap; $fell(rd_n) |-> sd >= CGAP; endproperty
  a_gap: assert property (p_gap) else $error("no rest gap");
  property p_min; $fell(rd_n) && pipelined |-> !rd_n[*3]; endproperty
  a_min: assert property (p_min) else $error("pulse short");
  property p_max; $fell(rd_n) && pipelined |-> ##[1:RMAX] rd_n; endproperty
  a_max: assert property (p_max) else $error("pulse long");
endmodule
bind hfa_host hfa_monitor hfa_monitor_i (.*);

// *** tb/hfa_adc_model.sv ***
// clockless converter model on the strobes
// assumes 8 channels; ready pulled up outside
`timescale 1ns/1ns
module hfa_adc_model (
  input wire logic cs_n, rd_n,
  input wire logic [2:0] chan_sel,
  output logic [7:0] result_bus,
  output logic done_n, ready_in
);
  logic [7:0] res = 8'h00, prev = 8'h00;
  logic [2:0] ch;
  logic conv = 1'b0;
  initial done_n = 1'b1;
  // both strobes low: latch channel, two nibble steps
  always @(negedge (cs_n | rd_n)) begin
    ch = chan_sel; prev = res; conv = 1'b1;
    #1000 res[7:4] = 4'(ch) + 4'h1;
    #600 res[3:0] = ~{1'b0, ch};
    done_n = 1'b0; conv = 1'b0;
  end
  always @(posedge (cs_n | rd_n)) done_n = 1'b1;
  assign ready_in = cs_n | !conv;
  assign result_bus = (cs_n | rd_n) ? ~prev : (conv ? prev : res);
endmodule

// *** tb/tb_hfa_host.sv ***
// bench for the host against the converter model
// assumes start is a one-cycle request
`timescale 1ns/1ns
module tb_hfa_host;
  logic ref_clk = 1'h0, resetn = 1'h0, start = 1'h0, pipelined = 1'h0;
  logic busy, result_valid, timeout, cs_n, rd_n, done_n, ready_in;
  logic [2:0] channel = 3'h0, chan_sel, result_chan;
  logic [7:0] result, result_bus;
  int n_mismatch = 0, num_checks = 0;
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
  hfa_host #(.CHANNELS(8)) hfa_host_i (.*);
  hfa_adc_model hfa_adc_model_i (.*);
  always #10 ref_clk = ~ref_clk;
  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic convert(input logic m, input logic [2:0] c);
    do @(negedge ref_clk); while (busy !== 1'h0);
    @(posedge ref_clk);
    pipelined <= m; channel <= c; start <= 1'h1;
    @(posedge ref_clk);
    start <= 1'h0;
    @(negedge ref_clk);
    `CHK("busy", 1'h1, busy)
    for (int k = 0; k < 400 && result_valid !== 1'h1; k++) @(negedge ref_clk);
    `CHK("valid", 1'h1, result_valid)
    `CHK("result", {4'(c) + 4'h1, ~{1'h0, c}}, result)
    `CHK("chan", c, result_chan)
    `CHK("timeout", 1'h0, timeout)
    repeat (40) @(posedge ref_clk);
  endtask
  task automatic scn_wait_state(); for (int c = 0; c < 8; c++) convert(1'h0, 3'(c)); endtask
  task automatic scn_pipelined();
    repeat (130) @(posedge ref_clk);
    convert(1'h1, 3'h7);
    convert(1'h1, 3'h0);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'h1;
    scn_wait_state();
    scn_pipelined();
    tally_and_finish();
  end
  initial begin #200000 n_mismatch++; tally_and_finish(); end
endmodule
